// [nfi_pkg.sv]
// nfi_pkg: constants for the nmi, bus fault and top-level irq enable block.
// assumes a 32-bit register port and a 50 MHz system clock.
`default_nettype none

package nfi_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int WDOG_LOW_WATER_US = 1792000;
	localparam int WDOG_LOW_WATER_CYC = WDOG_LOW_WATER_US * (1000 / CLK_PERIOD_NS);
	localparam int XTAL_LOSS_NS = 1000;
	localparam int XTAL_LOSS_CYC = XTAL_LOSS_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////////
	// register addresses
	localparam logic [31:0] ADDR_ENABLE_SET = 32'hE000E100;
	localparam logic [31:0] ADDR_ENABLE_CLR = 32'hE000E180;
	localparam logic [31:0] ADDR_AUX_FAULT = 32'h4000A000;
	localparam logic [31:0] ADDR_NMI_FLAG = 32'h4000A004;
	localparam logic [31:0] ADDR_NMI_CFG = 32'h4000A008;
	localparam logic [31:0] ADDR_CLK_CTRL = 32'h4000A00C;
	localparam logic [31:0] ADDR_WDOG_CTRL = 32'h4000A010;
	localparam logic [31:0] ADDR_WDOG_KICK = 32'h4000A014;

	////////////////////////////////////////////////////////////////////////////////
	// top-level line positions and reset values
	localparam int IRQ_LINES = 17;
	localparam int LINE_DEBUG = 16;
	localparam int LINE_EXT_PIN_D = 15;
	localparam int LINE_EXT_PIN_A = 12;
	localparam int LINE_CONVERTER = 11;
	localparam int LINE_RADIO_RECEIVE = 10;
	localparam int LINE_RADIO_TRANSMIT = 9;
	localparam int LINE_RADIO_TIMER = 8;
	localparam int LINE_SECURITY = 7;
	localparam int LINE_SERIAL_TWO = 6;
	localparam int LINE_SERIAL_ONE = 5;
	localparam int LINE_SLEEP_TIMER = 4;
	localparam int LINE_BASEBAND = 3;
	localparam int LINE_MANAGEMENT = 2;
	localparam int LINE_TIMER_TWO = 1;
	localparam int LINE_TIMER_ONE = 0;
	localparam logic [16:0] ENABLE_RST = 17'h00000;

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int AFS_BAD_WIDTH = 0;
	localparam int AFS_PROTECTED = 1;
	localparam int AFS_RESERVED = 2;
	localparam int AFS_MISSED = 3;
	localparam int NMI_CRYSTAL = 0;
	localparam int NMI_WDOG = 1;
	localparam int CLK_SEL_XTAL = 0;
	localparam int CLK_SRC_XTAL = 1;
	localparam int WDOG_EN = 0;
	localparam logic [3:0] AFS_RST = 4'h0;
	localparam logic [1:0] NMI_RST = 2'h0;

	////////////////////////////////////////////////////////////////////////////////
	// memory map used by the fault decoder
	localparam logic [15:0] APB_REGION = 16'h4000;
	localparam logic [3:0] APB_SYS_BLOCKS = 4'h4;
	localparam logic [11:0] APB_LAST_REG = 12'h0FC;
	localparam logic [11:0] AHB_SYS_REGION = 12'hE00;
	localparam logic [31:0] RAM_BASE = 32'h20000000;
	localparam logic [31:0] RAM_TOP = 32'h20003000;
	localparam logic [31:0] RAM_REGION_END = 32'h20100000;
	localparam logic [31:0] RAM_PROT_TOP = 32'h20000400;
	localparam logic [31:0] FLASH_BASE = 32'h08000000;
	localparam logic [31:0] FLASH_TOP = 32'h08030000;
	localparam logic [31:0] FLASH_REGION_END = 32'h08100000;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	// crystal supervision states
	typedef enum logic [1:0] {
		NFI_CK_RC,
		NFI_CK_XTAL,
		NFI_CK_DETECT,
		NFI_CK_SWITCH
	} nfi_clk_state_t;

endpackage : nfi_pkg

`default_nettype wire

// [nfi_top.sv]
// nfi_top: top-level irq enables, nmi sources and bus fault cause recording.
// assumes accesses reported on acc_* are already qualified by the bus and
// that crystal_good is a synchronous level from the oscillator monitor.
`default_nettype none

module nfi_top
	import nfi_pkg::*;
#(
	parameter int WDOG_CYCLES = WDOG_LOW_WATER_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [16:0] irq_line_in,
	output logic [16:0] irq_to_core,
	output logic nmi_out,
	input wire logic crystal_good,
	output logic system_clock_source,
	input wire logic acc_valid,
	input wire logic [31:0] acc_addr,
	input wire logic [1:0] acc_size,
	input wire logic acc_write,
	input wire logic acc_priv,
	output logic bus_fault,
	output logic hard_fault
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [16:0] enable_r;
	logic [3:0] afs_r;
	logic [3:0] afs_set;
	logic [1:0] nmi_flag_r;
	logic [1:0] nmi_cfg_r;
	logic [1:0] nmi_set;
	logic clk_sel_r;
	logic wdog_en_r;
	logic [26:0] wdog_cnt_r;
	logic [5:0] det_cnt_r;
	logic [31:0] rdata_r;
	logic bus_fault_r;
	logic hard_fault_r;
	nfi_clk_state_t ck_state_r;
	nfi_clk_state_t ck_state_nxt;
	logic wr_set, wr_clr, wr_afs, wr_flag, wr_cfg, wr_clk, wr_wden, wr_kick;
	logic in_apb, in_ahb_sys, in_ram, in_flash;
	logic bad_access_width_cause, prot_cause, rsvd_cause, any_cause;
	logic wdog_hit;

	localparam logic [26:0] WDOG_LAST = 27'(WDOG_CYCLES - 1);
	localparam logic [26:0] WDOG_STOP = 27'(WDOG_CYCLES);
	localparam logic [5:0] DET_LAST = 6'(XTAL_LOSS_CYC - 1);

	// write decode, one strobe per register
	assign wr_set = reg_wr && (reg_addr == ADDR_ENABLE_SET);
	assign wr_clr = reg_wr && (reg_addr == ADDR_ENABLE_CLR);
	assign wr_afs = reg_wr && (reg_addr == ADDR_AUX_FAULT);
	assign wr_flag = reg_wr && (reg_addr == ADDR_NMI_FLAG);
	assign wr_cfg = reg_wr && (reg_addr == ADDR_NMI_CFG);
	assign wr_clk = reg_wr && (reg_addr == ADDR_CLK_CTRL);
	assign wr_wden = reg_wr && (reg_addr == ADDR_WDOG_CTRL);
	assign wr_kick = reg_wr && (reg_addr == ADDR_WDOG_KICK);

	////////////////////////////////////////////////////////////////////////////////
	// top-level enables
	// set on ones
	// clear on ones; a set and clear cannot share a cycle on this port
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enable_r <= ENABLE_RST;
		end else if (wr_set) begin
			enable_r <= enable_r | reg_wdata[16:0];
		end else if (wr_clr) begin
			enable_r <= enable_r & ~reg_wdata[16:0];
		end
	end

	// lines pass as levels, gated only by their enable
	// bit n of the enable gates line n
	assign irq_to_core = irq_line_in & enable_r;

	////////////////////////////////////////////////////////////////////////////////
	// crystal supervision
	// detect loss, then fall back to rc
	always_comb begin
		ck_state_nxt = ck_state_r;
		case (ck_state_r)
			NFI_CK_RC: begin
				if (clk_sel_r && crystal_good) begin
					ck_state_nxt = NFI_CK_XTAL;
				end
			end
			NFI_CK_XTAL: begin
				if (!clk_sel_r) begin
					ck_state_nxt = NFI_CK_RC;
				end else if (!crystal_good) begin
					ck_state_nxt = NFI_CK_DETECT;
				end
			end
			NFI_CK_DETECT: begin
				if (crystal_good) begin
					ck_state_nxt = NFI_CK_XTAL;
				end else if (det_cnt_r == DET_LAST) begin
					ck_state_nxt = NFI_CK_SWITCH;
				end
			end
			NFI_CK_SWITCH: begin
				ck_state_nxt = NFI_CK_RC;
			end
			default: begin
				ck_state_nxt = NFI_CK_RC;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ck_state_r <= NFI_CK_RC;
		end else begin
			ck_state_r <= ck_state_nxt;
		end
	end

	// loss must persist a full window so a glitch does not force a switch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			det_cnt_r <= 6'h00;
		end else if (ck_state_r == NFI_CK_DETECT) begin
			det_cnt_r <= det_cnt_r + 6'h01;
		end else begin
			det_cnt_r <= 6'h00;
		end
	end

	// crystal select; hardware drops it on a forced switch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clk_sel_r <= 1'b0;
		end else if (ck_state_r == NFI_CK_SWITCH) begin
			clk_sel_r <= 1'b0;
		end else if (wr_clk) begin
			clk_sel_r <= reg_wdata[CLK_SEL_XTAL];
		end
	end

	// source stays on crystal during the detection window
	assign system_clock_source = (ck_state_r == NFI_CK_XTAL) || (ck_state_r == NFI_CK_DETECT);

	////////////////////////////////////////////////////////////////////////////////
	// watchdog low water mark
	assign wdog_hit = wdog_en_r && (wdog_cnt_r == WDOG_LAST) && !wr_kick;

	// enable bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wdog_en_r <= 1'b0;
		end else if (wr_wden) begin
			wdog_en_r <= reg_wdata[WDOG_EN];
		end
	end

	// count while active; parks one past the mark so the event fires once per lapse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wdog_cnt_r <= 27'h0000000;
		end else if (!wdog_en_r || wr_kick) begin
			wdog_cnt_r <= 27'h0000000;
		end else if (wdog_cnt_r != WDOG_STOP) begin
			wdog_cnt_r <= wdog_cnt_r + 27'h0000001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// nmi second-level flags and config
	// crystal flag after detection and switch
	// watchdog flag on low water mark
	assign nmi_set[NMI_CRYSTAL] = (ck_state_r == NFI_CK_SWITCH);
	assign nmi_set[NMI_WDOG] = wdog_hit;

	// write one to clear; a new event in the clearing cycle wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nmi_flag_r <= NMI_RST;
		end else begin
			nmi_flag_r <= (nmi_flag_r & ~(wr_flag ? reg_wdata[1:0] : 2'h0)) | nmi_set;
		end
	end

	// config bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nmi_cfg_r <= NMI_RST;
		end else if (wr_cfg) begin
			nmi_cfg_r <= reg_wdata[1:0];
		end
	end

	// only these two flags feed the nmi
	// level output, holds until flags or their config bits are cleared
	assign nmi_out = |(nmi_flag_r & nmi_cfg_r);

	////////////////////////////////////////////////////////////////////////////////
	// bus fault decode
	assign in_apb = (acc_addr[31:16] == APB_REGION);
	assign in_ahb_sys = (acc_addr[31:20] == AHB_SYS_REGION);
	assign in_ram = (acc_addr >= RAM_BASE) && (acc_addr < RAM_REGION_END);
	assign in_flash = (acc_addr >= FLASH_BASE) && (acc_addr < FLASH_REGION_END);

	assign bad_access_width_cause = (in_apb && (acc_size != SIZE_WORD))
		|| ((acc_size == SIZE_WORD) && (acc_addr[1:0] != 2'h0));

	// unprivileged write to system peripheral or protected ram
	assign prot_cause = acc_write && !acc_priv
		&& ((in_apb && (acc_addr[15:12] < APB_SYS_BLOCKS)) || in_ahb_sys
		|| ((acc_addr >= RAM_BASE) && (acc_addr < RAM_PROT_TOP)));

	// beyond the last register of a block
	// above top of ram or flash
	assign rsvd_cause = (in_apb && (acc_addr[11:0] > APB_LAST_REG))
		|| (in_ram && (acc_addr >= RAM_TOP))
		|| (in_flash && (acc_addr >= FLASH_TOP));

	assign any_cause = acc_valid && (bad_access_width_cause || prot_cause || rsvd_cause);

	// one bit per cause, several may set together
	// a fault while a cause is held sets missed
	always_comb begin
		afs_set = 4'h0;
		if (acc_valid) begin
			afs_set[AFS_BAD_WIDTH] = bad_access_width_cause;
			afs_set[AFS_PROTECTED] = prot_cause;
			afs_set[AFS_RESERVED] = rsvd_cause;
			afs_set[AFS_MISSED] = any_cause && (afs_r != AFS_RST);
		end
	end

	// status, write one to clear, set wins over clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			afs_r <= AFS_RST;
		end else begin
			afs_r <= (afs_r & ~(wr_afs ? reg_wdata[3:0] : 4'h0)) | afs_set;
		end
	end

	// second fault escalates to hard fault, which preempts bus fault
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_fault_r <= 1'b0;
			hard_fault_r <= 1'b0;
		end else begin
			hard_fault_r <= any_cause && (afs_r != AFS_RST);
			bus_fault_r <= any_cause && (afs_r == AFS_RST);
		end
	end

	assign bus_fault = bus_fault_r;
	assign hard_fault = hard_fault_r;

	////////////////////////////////////////////////////////////////////////////////
	// read data, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_r <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				// both enable addresses show the enables
				// bits 31 to 17 read zero
				ADDR_ENABLE_SET, ADDR_ENABLE_CLR: begin
					rdata_r <= {15'h0000, enable_r};
				end
				ADDR_AUX_FAULT: begin
					rdata_r <= {28'h0000000, afs_r};
				end
				ADDR_NMI_FLAG: begin
					rdata_r <= {30'h00000000, nmi_flag_r};
				end
				ADDR_NMI_CFG: begin
					rdata_r <= {30'h00000000, nmi_cfg_r};
				end
				ADDR_CLK_CTRL: begin
					rdata_r <= {30'h00000000, system_clock_source, clk_sel_r};
				end
				ADDR_WDOG_CTRL: begin
					rdata_r <= {31'h00000000, wdog_en_r};
				end
				default: begin
					rdata_r <= 32'h00000000;
				end
			endcase
		end
	end

	assign reg_rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////////////
	// assertions
	sequence crystal_lost_s;
		(ck_state_r == NFI_CK_DETECT) && !crystal_good && (det_cnt_r == DET_LAST);
	endsequence

	sequence switch_done_s;
		(ck_state_r == NFI_CK_SWITCH) ##1 (!system_clock_source && nmi_flag_r[NMI_CRYSTAL]);
	endsequence

	enable_set_a: assert property (@(posedge clk) disable iff (rst)
		wr_set |=> ((enable_r & $past(reg_wdata[16:0])) == $past(reg_wdata[16:0]))
		&& ((enable_r & ~$past(reg_wdata[16:0])) == ($past(enable_r) & ~$past(reg_wdata[16:0]))))
		else $error("enable set write misbehaved");

	enable_clr_a: assert property (@(posedge clk) disable iff (rst)
		wr_clr |=> ((enable_r & $past(reg_wdata[16:0])) == 17'h00000)
		&& ((enable_r & ~$past(reg_wdata[16:0])) == ($past(enable_r) & ~$past(reg_wdata[16:0]))))
		else $error("enable clear write misbehaved");

	enable_read_a: assert property (@(posedge clk) disable iff (rst)
		(reg_rd && (reg_addr == ADDR_ENABLE_CLR) && !reg_wr) |=> (reg_rdata == {15'h0000, $past(enable_r)}))
		else $error("enable read wrong");

	crystal_switch_a: assert property (@(posedge clk) disable iff (rst)
		crystal_lost_s |=> switch_done_s)
		else $error("crystal loss not handled");

	nmi_source_a: assert property (@(posedge clk) disable iff (rst)
		((nmi_flag_r != NMI_RST) && ((nmi_flag_r & nmi_cfg_r) == NMI_RST)) |-> !nmi_out)
		else $error("nmi without config");

	wdog_flag_a: assert property (@(posedge clk) disable iff (rst)
		wdog_hit |=> nmi_flag_r[NMI_WDOG] && (!nmi_cfg_r[NMI_WDOG] || nmi_out))
		else $error("watchdog flag not set");

	width_fault_a: assert property (@(posedge clk) disable iff (rst)
		(acc_valid && in_apb && (acc_size != SIZE_WORD)) |=> afs_r[AFS_BAD_WIDTH] && (bus_fault || hard_fault))
		else $error("width fault missing");

	prot_fault_a: assert property (@(posedge clk) disable iff (rst)
		(acc_valid && acc_write && !acc_priv && in_ahb_sys) |=> afs_r[AFS_PROTECTED])
		else $error("protection fault missing");

	reserved_fault_a: assert property (@(posedge clk) disable iff (rst)
		(acc_valid && in_ram && (acc_addr >= RAM_TOP)) |=> afs_r[AFS_RESERVED])
		else $error("reserved fault missing");

	missed_fault_a: assert property (@(posedge clk) disable iff (rst)
		(any_cause && (afs_r != AFS_RST)) |=> afs_r[AFS_MISSED] && hard_fault && !bus_fault)
		else $error("second fault not escalated");

endmodule : nfi_top

`default_nettype wire

// [nfi_core_model.sv]
// nfi_core_model: behavioural core that issues bus accesses to be checked
// and counts the bus fault and hard fault pulses that come back.
// assumes the bench calls access() from one process only.
`default_nettype none

module nfi_core_model
	import nfi_pkg::*;
(
	input wire logic clk,
	output logic acc_valid,
	output logic [31:0] acc_addr,
	output logic [1:0] acc_size,
	output logic acc_write,
	output logic acc_priv,
	input wire logic bus_fault,
	input wire logic hard_fault
);
	timeunit 1ns;
	timeprecision 1ps;

	int bf_cnt = 0;
	int hf_cnt = 0;

	////////////////////////////////////////////////////////////////////////////////
	// idle: qualifiers show a scrambled value so nothing is read off a dead bus
	initial begin
		acc_valid = 1'b0;
		acc_addr = 32'h5A5A5A5A;
		acc_size = 2'h3;
		acc_write = 1'b0;
		acc_priv = 1'b1;
	end

	// no protection unit, so faulting accesses really reach the block
	task automatic access(input logic [31:0] a, input logic [1:0] s, input logic w,
		input logic p);
		@(posedge clk);
		acc_valid <= 1'b1;
		acc_addr <= a;
		acc_size <= s;
		acc_write <= w;
		acc_priv <= p;
		@(posedge clk);
		acc_valid <= 1'b0;
		acc_addr <= ~a;
		acc_size <= ~s;
	endtask : access

	// fault pulses are one cycle long, so they are counted every edge
	always @(posedge clk) begin
		if (bus_fault === 1'b1) bf_cnt++;
		if (hard_fault === 1'b1) hf_cnt++;
	end

endmodule : nfi_core_model

`default_nettype wire

// [nfi_tb.sv]
// nfi_tb: self-checking bench for nfi_top with a random enable register walk,
// a table of faulting accesses, crystal loss and a short watchdog.
// assumes the core model drives the access port.
`default_nettype none

module tb
	import nfi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int WD = 20; // short watchdog so the run stays small
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, crystal_good = 1'b1;
	logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata, rd, wd;
	logic [16:0] irq_line_in = 17'h00000, irq_to_core, en = 17'h00000;
	logic nmi_out, system_clock_source, acc_valid, acc_write, acc_priv, bus_fault;
	logic hard_fault;
	logic [31:0] acc_addr;
	logic [1:0] acc_size;
	int err_count = 0, cmp_count = 0, cyc = 0, n, b0;

	nfi_top #(.WDOG_CYCLES(WD)) i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq_line_in(irq_line_in), .irq_to_core(irq_to_core), .nmi_out(nmi_out),
		.crystal_good(crystal_good), .system_clock_source(system_clock_source),
		.acc_valid(acc_valid), .acc_addr(acc_addr), .acc_size(acc_size),
		.acc_write(acc_write), .acc_priv(acc_priv), .bus_fault(bus_fault),
		.hard_fault(hard_fault));
	nfi_core_model i_core (.clk(clk), .acc_valid(acc_valid), .acc_addr(acc_addr),
		.acc_size(acc_size), .acc_write(acc_write), .acc_priv(acc_priv),
		.bus_fault(bus_fault), .hard_fault(hard_fault));

	////////////////////////////////////////////////////////////////////////////////
	// clock and a hang limit well above the expected few hundred cycles
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			summarize();
		end
	end

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [31:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		// data stand in the cycle after the strobe; taken at the edge that closes it
		@(posedge clk);
		rd = reg_rdata;
	endtask : rdr

	// expected fault causes worked out from the memory map
	function automatic logic [3:0] exp_afs(logic [31:0] a, logic [1:0] s, logic w, logic p);
		logic apb;
		logic [3:0] e;
		apb = (a[31:16] == APB_REGION);
		e = 4'h0;
		e[AFS_BAD_WIDTH] = (apb && s != SIZE_WORD) || (s == SIZE_WORD && a[1:0] != 2'h0);
		e[AFS_PROTECTED] = !p && w && ((apb && a[15:12] < APB_SYS_BLOCKS)
			|| a[31:20] == AHB_SYS_REGION || (a >= RAM_BASE && a < RAM_PROT_TOP));
		e[AFS_RESERVED] = (apb && a[11:0] > APB_LAST_REG)
			|| (a >= RAM_TOP && a < RAM_REGION_END) || (a >= FLASH_TOP && a < FLASH_REGION_END);
		return e;
	endfunction : exp_afs

	// last entry: unprivileged write into the system bus region
	logic [31:0] fa [8] = '{32'h40000000, 32'h20000001, 32'h40000010, 32'h40000100,
		32'h20003000, 32'h08030004, 32'h40001002, 32'hE000E100};
	logic [1:0] fs [8] = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h2};
	logic fw [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
	logic fp [8] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(10));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rdr(ADDR_ENABLE_SET);
		chk(rd, 32'h0, "enable reset");
		// random set and clear walk, both views read back every time
		for (int i = 0; i < 40; i++) begin
			wd = $urandom;
			irq_line_in <= 17'($urandom);
			wr(i[0] ? ADDR_ENABLE_CLR : ADDR_ENABLE_SET, wd);
			en = i[0] ? (en & ~wd[16:0]) : (en | wd[16:0]);
			rdr(ADDR_ENABLE_SET);
			chk(rd, {15'h0, en}, "enable via set");
			rdr(ADDR_ENABLE_CLR);
			chk(rd, {15'h0, en}, "enable via clear");
			chk({15'h0, irq_to_core}, {15'h0, irq_line_in & en}, "line gating");
		end
		// mid-run reset drops every enable and the read data
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		chk({15'h0, irq_to_core}, 32'h0, "lines in reset");
		chk(reg_rdata, 32'h0, "read data in reset");
		rst <= 1'b0;
		en = 17'h00000;
		rdr(ADDR_ENABLE_CLR);
		chk(rd, 32'h0, "enable after reset");
		// every line bit by its own position
		wr(ADDR_ENABLE_CLR, 32'hFFFFFFFF);
		irq_line_in <= 17'h1FFFF;
		for (int i = LINE_TIMER_ONE; i <= LINE_DEBUG; i++) begin
			wr(ADDR_ENABLE_SET, 32'h1 << i);
			@(posedge clk);
			chk({15'h0, irq_to_core}, 32'h1 << i, "single line");
			wr(ADDR_ENABLE_CLR, 32'h1 << i);
		end
		rdr(32'h4000A0F0);
		chk(rd, 32'h0, "unmapped read");
		// fault table: clear causes, make one access, check causes and pulse
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_AUX_FAULT, 32'hF);
			b0 = i_core.bf_cnt;
			i_core.access(fa[i], fs[i], fw[i], fp[i]);
			repeat (2) @(posedge clk);
			rdr(ADDR_AUX_FAULT);
			chk(rd, {28'h0, exp_afs(fa[i], fs[i], fw[i], fp[i])}, "fault cause");
			chk(i_core.bf_cnt - b0, 1, "bus fault pulse");
		end
		// second fault while causes are held
		b0 = i_core.hf_cnt;
		i_core.access(32'h40000000, 2'h1, 1'b0, 1'b1);
		repeat (2) @(posedge clk);
		rdr(ADDR_AUX_FAULT);
		chk(rd[AFS_MISSED], 1'b1, "missed cause");
		chk(i_core.hf_cnt - b0, 1, "hard fault pulse");
		wr(ADDR_AUX_FAULT, 32'hF);
		// crystal: brief dropout recovers, long loss falls back to rc
		wr(ADDR_NMI_CFG, 32'h3);
		wr(ADDR_CLK_CTRL, 32'h1 << CLK_SEL_XTAL);
		repeat (2) @(posedge clk);
		chk(system_clock_source, 1'b1, "on crystal");
		crystal_good <= 1'b0;
		repeat (10) @(posedge clk);
		crystal_good <= 1'b1;
		repeat (3) @(posedge clk);
		chk(system_clock_source, 1'b1, "dropout ride-through");
		chk(nmi_out, 1'b0, "no nmi after dropout");
		crystal_good <= 1'b0;
		n = 0;
		while (system_clock_source === 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk(n >= XTAL_LOSS_CYC && n <= XTAL_LOSS_CYC + 3, 1, "switch delay");
		#1 chk(nmi_out, 1'b1, "crystal nmi");
		rdr(ADDR_NMI_FLAG);
		chk(rd[1:0], 2'h1 << NMI_CRYSTAL, "crystal flag");
		wr(ADDR_NMI_FLAG, 32'h3);
		crystal_good <= 1'b1;
		#1 chk(nmi_out, 1'b0, "nmi cleared");
		// watchdog with its nmi source masked first
		wr(ADDR_NMI_CFG, 32'h0);
		wr(ADDR_WDOG_CTRL, 32'h1 << WDOG_EN);
		repeat (WD + 4) @(posedge clk);
		rdr(ADDR_NMI_FLAG);
		chk(rd[1:0], 2'h1 << NMI_WDOG, "watchdog flag");
		chk(nmi_out, 1'b0, "masked nmi");
		wr(ADDR_NMI_CFG, 32'h1 << NMI_WDOG);
		#1 chk(nmi_out, 1'b1, "watchdog nmi");
		wr(ADDR_WDOG_CTRL, 32'h0);
		wr(ADDR_WDOG_KICK, 32'h1);
		wr(ADDR_NMI_FLAG, 32'h3);
		#1 chk(nmi_out, 1'b0, "nmi released");
		summarize();
	end

endmodule : tb

`default_nettype wire
